// ### design/picx_pkg.sv
// package: constants and types of the prioritized interrupt controller
package picx_pkg;
  localparam int NUM_SW      = 8;
  localparam int NUM_PERIPH  = 191;
  localparam int NUM_RSVD    = 165;
  localparam int NUM_SRC     = NUM_SW + NUM_PERIPH + NUM_RSVD;
  localparam int VEC_W       = 9;
  localparam int PRIO_W      = 4;
  localparam int NUM_PRIO    = 16;
  localparam int STACK_DEPTH = NUM_PRIO;
  localparam int SP_W        = 5;
  localparam int SW_BASE     = 0;
  localparam int PERIPH_BASE = SW_BASE + NUM_SW;
  localparam int REQ_LATENCY = 3;

  localparam logic [PRIO_W-1:0] PRIO_RESET = 4'h0;
  localparam logic [VEC_W-1:0]  VEC_RESET  = 9'h000;
  localparam logic [SP_W-1:0]   SP_RESET   = 5'h00;
  localparam logic [SP_W-1:0]   SP_FULL    = 5'h10;

  typedef struct packed {
    logic              valid;
    logic [PRIO_W-1:0] prio;
    logic [VEC_W-1:0]  vec;
  } picx_win_type;

  localparam picx_win_type WIN_RESET = '{valid: 1'b0, prio: PRIO_RESET, vec: VEC_RESET};
endpackage

// ### design/picx_ctrl.sv
// prioritized preemptive interrupt controller with priority lifo
`timescale 1ns/1ps
`default_nettype none

module picx_ctrl
  import picx_pkg::*;
(
  input  wire logic                    core_clk,     // system clock, 40 MHz
  input  wire logic                    rst_b,        // async reset, active low
  input  wire logic [NUM_PERIPH-1:0]   periph_irq,   // peripheral requests, level
  input  wire logic [NUM_SW-1:0]       sw_set,       // set software request bits
  input  wire logic [NUM_SW-1:0]       sw_clr,       // clear software request bits
  output logic      [NUM_SW-1:0]       sw_pend,      // software request bits state
  input  wire logic                    prio_wr,      // priority table write strobe
  input  wire logic [VEC_W-1:0]        prio_idx,     // source number to program
  input  wire logic [PRIO_W-1:0]       prio_val,     // priority value to program
  input  wire logic                    cur_wr,       // current priority write strobe
  input  wire logic [PRIO_W-1:0]       cur_val,      // current priority write value
  output logic      [PRIO_W-1:0]       cur_prio,     // current priority
  input  wire logic                    hw_vec_mode,  // 1: vector port, 0: register read
  input  wire logic                    iack,         // core acknowledge, vector port mode
  input  wire logic                    vec_rd,       // vector register read, acks in reg mode
  input  wire logic                    eoi,          // end of service strobe
  output logic                         irq_req,      // request to core
  output logic      [VEC_W-1:0]        irq_vec,      // vector port to core
  output logic      [VEC_W-1:0]        vec_reg,      // vector register contents
  output logic      [SP_W-1:0]         stack_lvl,    // lifo fill level
  input  wire logic                    nmi_pin,      // non-maskable pin, async
  output logic                         nmi_out       // non-maskable to core
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and pending vector

  logic [NUM_SRC-1:0][PRIO_W-1:0]      prio_q;
  logic [NUM_SW-1:0]                   sw_pend_q;
  logic [NUM_SRC-1:0]                  pend;
  picx_win_type                        win_d;
  picx_win_type                        win_q;
  logic                                req_q;
  logic [PRIO_W-1:0]                   cur_q;
  logic [STACK_DEPTH-1:0][PRIO_W-1:0]  stack_q;
  logic [SP_W-1:0]                     sp_q;
  logic [VEC_W-1:0]                    vec_q;
  logic                                ack_fire;
  logic                                pop_fire;
  logic                                nmi_meta_q;
  logic                                nmi_q;

  // reserved slots have no input and never pend
  assign pend = {{NUM_RSVD{1'b0}}, periph_irq, sw_pend_q};

  // highest priority, lowest number on ties
  function automatic picx_win_type arb(input logic [NUM_SRC-1:0]             p,
                                       input logic [NUM_SRC-1:0][PRIO_W-1:0] pr);
    picx_win_type w;
    w = WIN_RESET;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (p[i] && (!w.valid || pr[i] > w.prio)) begin
        w.valid = 1'b1;
        w.prio  = pr[i];
        w.vec   = VEC_W'(i);
      end
    end
    return w;
  endfunction

  assign win_d    = arb(pend, prio_q);
  assign ack_fire = req_q && (hw_vec_mode ? iack : vec_rd);
  assign pop_fire = eoi && !ack_fire && (sp_q != SP_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // priority table

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prio_q <= '0;
    end else if (prio_wr && (32'(prio_idx) < NUM_SRC)) begin
      prio_q[prio_idx] <= prio_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software settable requests, set wins over clear

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_pend_q <= '0;
    end else begin
      sw_pend_q <= (sw_pend_q & ~sw_clr) | sw_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration stage and request to core

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_q <= WIN_RESET;
    end else begin
      win_q <= win_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= 1'b0;
    end else begin
      req_q <= win_q.valid && (win_q.prio > cur_q) && !ack_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current priority and lifo

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= PRIO_RESET;
    end else if (ack_fire) begin
      cur_q <= win_q.prio;
    end else if (pop_fire) begin
      cur_q <= stack_q[sp_q - 5'h01];
    end else if (cur_wr) begin
      cur_q <= cur_val;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_q <= '0;
      sp_q    <= SP_RESET;
    end else if (ack_fire && sp_q != SP_FULL) begin
      stack_q[sp_q[3:0]] <= cur_q;
      sp_q               <= sp_q + 5'h01;
    end else if (pop_fire) begin
      sp_q <= sp_q - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector delivery

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_q <= VEC_RESET;
    end else if (ack_fire) begin
      vec_q <= win_q.vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // non-maskable path, synchroniser only

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_meta_q <= 1'b0;
      nmi_q      <= 1'b0;
    end else begin
      nmi_meta_q <= nmi_pin;
      nmi_q      <= nmi_meta_q;
    end
  end

  assign sw_pend   = sw_pend_q;
  assign cur_prio  = cur_q;
  assign irq_req   = req_q;
  assign irq_vec   = hw_vec_mode ? win_q.vec : VEC_RESET;
  assign vec_reg   = vec_q;
  assign stack_lvl = sp_q;
  assign nmi_out   = nmi_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic quiet;
  assign quiet = !ack_fire && !cur_wr && !eoi;

  sequence qual_s;
    win_d.valid && (win_d.prio > cur_q) && quiet;
  endsequence

  sequence hold_s;
    quiet;
  endsequence

  req_latency_a : assert property (qual_s ##1 hold_s |=> irq_req)
    else $error("request not raised within three clocks");
  req_above_a : assert property (irq_req |-> $past(win_q.prio) > $past(cur_q))
    else $error("request at or below current priority");
  lifo_push_a : assert property (ack_fire && sp_q != SP_FULL |=> sp_q == $past(sp_q) + 5'h01)
    else $error("lifo not pushed on acknowledge");
  lifo_pop_a : assert property (pop_fire |=> cur_q == $past(stack_q[sp_q - 5'h01]))
    else $error("priority not restored on end of service");
  ceil_write_a : assert property (cur_wr && !ack_fire && !pop_fire |=> cur_q == $past(cur_val))
    else $error("current priority write lost");
  sw_set_a : assert property (sw_set != '0 |=> (sw_pend & $past(sw_set)) == $past(sw_set))
    else $error("software request set lost");
  vec_latch_a : assert property (ack_fire |=> vec_reg == $past(win_q.vec) && cur_prio == $past(win_q.prio))
    else $error("vector or priority not taken on acknowledge");
  prio_prog_a : assert property (prio_wr && 32'(prio_idx) < NUM_SRC |=> prio_q[$past(prio_idx)] == $past(prio_val))
    else $error("priority table write lost");
  nmi_pass_a : assert property (nmi_out == $past(nmi_pin, 2))
    else $error("non-maskable path delayed or gated");
  no_ack_req_a : assert property (ack_fire |=> !irq_req)
    else $error("request still raised after acknowledge");

endmodule

`default_nettype wire

// ### dv/picx_core_model.sv
// core-side acknowledge model for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module picx_core_model (
  input  wire logic       core_clk, // system clock
  input  wire logic       rst_b,    // async reset, active low
  input  wire logic       irq_req,  // request from controller
  input  wire logic       hw_mode,  // 1: iack, 0: vec_rd
  input  wire logic       ack_en,   // allow acknowledges
  input  wire logic [1:0] wait_n,   // extra cycles before ack
  output logic            iack,     // vector port acknowledge
  output logic            vec_rd    // register read acknowledge
);
  logic [1:0] cnt_q;
  logic [1:0] wn_q;
  logic       en_q;
  logic       mode_q;
  // bench controls move on the falling edge, so take them on the rising one
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 1'h0;
      mode_q <= 1'h1;
      wn_q <= 2'h0;
    end else begin
      en_q <= ack_en;
      mode_q <= hw_mode;
      wn_q <= wait_n;
    end
  end
  // held until the edge that sees irq_req low
  always @(negedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 2'h0;
      iack <= 1'h0;
      vec_rd <= 1'h0;
    end else if (irq_req && en_q && cnt_q == wn_q) begin
      iack <= mode_q;
      vec_rd <= !mode_q;
    end else begin
      iack <= 1'h0;
      vec_rd <= 1'h0;
      cnt_q <= (irq_req && en_q) ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ### dv/picx_ctrl_tb.sv
// self-checking bench for the prioritized interrupt controller
`timescale 1ns/1ps
`default_nettype none
module picx_ctrl_tb;
  import picx_pkg::*;
  logic core_clk = 0, rst_b = 0, prio_wr = 0, cur_wr = 0, hw_vec_mode = 1;
  logic iack, vec_rd, eoi = 0, nmi_pin = 0, ack_en = 0, irq_req, nmi_out;
  logic [NUM_PERIPH-1:0] periph_irq = '0;
  logic [NUM_SW-1:0]     sw_set = '0, sw_clr = '0, sw_pend;
  logic [VEC_W-1:0]      prio_idx = '0, irq_vec, vec_reg, ev;
  logic [PRIO_W-1:0]     prio_val = '0, cur_val = '0, cur_prio, pr;
  logic [SP_W-1:0]       stack_lvl;
  logic [1:0]            wait_n = '0;
  logic [8:0]            q[$];
  int num_errors = 0, num_checks = 0, seed = 31, cyc = 0, src;
  initial forever #12.5 core_clk = ~core_clk;
  picx_ctrl picx_ctrl_inst (.core_clk, .rst_b, .periph_irq, .sw_set, .sw_clr, .sw_pend,
    .prio_wr, .prio_idx, .prio_val, .cur_wr, .cur_val, .cur_prio, .hw_vec_mode, .iack,
    .vec_rd, .eoi, .irq_req, .irq_vec, .vec_reg, .stack_lvl, .nmi_pin, .nmi_out);
  picx_core_model picx_core_model_inst (.core_clk, .rst_b, .irq_req, .hw_mode(hw_vec_mode),
    .ack_en, .wait_n, .iack, .vec_rd);
  task automatic chk(input string nm, input logic [8:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic setp(input int i, input logic [3:0] v);
    prio_wr = 1;
    prio_idx = i[8:0];
    prio_val = v;
    tick(1);
    prio_wr = 0;
  endtask
  task automatic wcur(input logic [3:0] v);
    cur_wr = 1;
    cur_val = v;
    tick(1);
    cur_wr = 0;
  endtask
  task automatic raise(input int s, input logic v);
    if (s < 8) begin
      sw_set[s] = v;
      sw_clr[s] = !v;
    end else periph_irq[s-8] = v;
  endtask
  task automatic pulse_eoi();
    eoi = 1;
    tick(1);
    eoi = 0;
    tick(1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // each acknowledge takes the oldest expected vector; look just before the edge
  always @(negedge core_clk) begin
    #12;
    if (irq_req && (hw_vec_mode ? iack : vec_rd)) begin
      ev = q.size() ? q.pop_front() : 9'h1ff;
      chk("irq_vec", hw_vec_mode ? ev : 9'h000, irq_vec);
      @(posedge core_clk);
      #1 chk("vec_reg", ev, vec_reg);
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    tick(16);
    rst_b = 1;
    tick(1);
    chk("cur_prio", 0, cur_prio);
    chk("irq_req", 0, irq_req);
    $display("test reset done");
    setp(8, 5);
    tick(1);
    setp(9, 5);
    periph_irq[1:0] = 2'h3;
    tick(3);
    chk("irq_req", 1, irq_req);
    q.push_back(9'h008);
    ack_en = 1;
    tick(5);
    ack_en = 0;
    chk("cur_prio", 5, cur_prio);
    tick(4);
    chk("irq_req", 0, irq_req);
    setp(3, 7);
    raise(3, 1);
    q.push_back(9'h003);
    ack_en = 1;
    tick(8);
    ack_en = 0;
    chk("stack_lvl", 2, stack_lvl);
    chk("sw_pend", 9'h008, sw_pend);
    raise(3, 0);
    periph_irq = '0;
    pulse_eoi();
    chk("cur_prio", 5, cur_prio);
    chk("sw_pend", 9'h000, sw_pend);
    pulse_eoi();
    chk("stack_lvl", 0, stack_lvl);
    $display("test nesting done");
    repeat (6) begin
      src = {$random(seed)} % 199;
      pr = 4'({$random(seed)} % 15 + 1);
      wait_n = 2'($random(seed));
      hw_vec_mode = !hw_vec_mode;
      setp(src, pr);
      wcur(pr);
      raise(src, 1);
      ack_en = 1;
      tick(4);
      chk("irq_req", 0, irq_req);
      q.push_back(src[8:0]);
      wcur(4'h0);
      tick(9);
      ack_en = 0;
      chk("cur_prio", pr, cur_prio);
      raise(src, 0);
      pulse_eoi();
      chk("cur_prio", 0, cur_prio);
    end
    $display("test random done");
    nmi_pin = 1;
    tick(2);
    chk("nmi_out", 1, nmi_out);
    $display("test nmi done");
    chk("pending_acks", 9'h000, 9'(q.size()));
    results();
  end
endmodule
`default_nettype wire
